// ---- verilog/ismc_pkg.sv ----
// shared constants and types for the two-wire serial memory link
package ismc_pkg;

   // ==================================================
   // memory geometry
   localparam int ISMC_ADDR_W = 11;
   localparam int ISMC_MEM_DEPTH = 2048;
   localparam int ISMC_UPPER_W = 3;
   localparam logic [ISMC_ADDR_W-1:0] ISMC_ADDR_ZERO = 11'h000;

   // ==================================================
   // device address word layout
   localparam int ISMC_TYPE_MSB = 7;
   localparam int ISMC_TYPE_LSB = 4;
   localparam int ISMC_UPPER_MSB = 3;
   localparam int ISMC_UPPER_LSB = 1;
   localparam int ISMC_RW_BIT = 0;
   // arbitrary value, not tied to any real part
   localparam logic [3:0] ISMC_TYPE_DEFAULT = 4'h5;

   // ==================================================
   // bit framing: bits 0..7 carry data, bit 8 is the acknowledge
   localparam logic [3:0] ISMC_LAST_BIT = 4'h7;
   localparam logic [3:0] ISMC_ACK_BIT = 4'h8;
   localparam logic [3:0] ISMC_BIT_ZERO = 4'h0;
   localparam logic [3:0] ISMC_BIT_ONE = 4'h1;

   // ==================================================
   // link timing on the master end
   localparam int ISMC_CLK_NS = 4;
   localparam int ISMC_SCL_PERIOD_NS = 1000;
   // one quarter of the link clock period, rounded down
   localparam int ISMC_QTR_CYC = ISMC_SCL_PERIOD_NS / 4 / ISMC_CLK_NS;
   localparam logic [7:0] ISMC_QTR_LAST = 8'(ISMC_QTR_CYC - 1);
   localparam logic [1:0] ISMC_PH_LAST = 2'h3;

   // ==================================================
   // master command codes
   typedef enum logic [2:0] {
      ISMC_OP_START,
      ISMC_OP_STOP,
      ISMC_OP_WRITE,
      ISMC_OP_READ,
      ISMC_OP_CLOCKS
   } ismc_op_e;

endpackage : ismc_pkg

// ---- verilog/ismc_link_if.sv ----
// two-wire link between the master end and the memory end
`timescale 1ns/1ns
interface ismc_link_if;
   logic scl;
   logic sda_m_oe;
   logic sda_d_oe;
   logic sda;
   logic wp_o;
   logic wp_oe;
   logic wp;

   // open drain with pull-up: any enable pulls the line low
   assign sda = !(sda_m_oe || sda_d_oe);
   // an unconnected protect pin falls to the internal pull-down
   assign wp = wp_oe ? wp_o : 1'b0;

   modport master (
      output scl,
      output sda_m_oe,
      output wp_o,
      output wp_oe,
      input sda
   );

   modport dev (
      input scl,
      input sda,
      input wp,
      output sda_d_oe
   );
endinterface : ismc_link_if

// ---- verilog/ismc_sync2.sv ----
// two-stage synchroniser for a single level
`timescale 1ns/1ns
module ismc_sync2
(
   input wire logic clk,
   input wire logic rst,
   input wire logic d,
   output logic q
);
   logic meta_q;

   // ==================================================
   // the first stage feeds only the second
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_q <= 1'b0;
         q <= 1'b0;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : ismc_sync2

// ---- verilog/ismc_mem_dev.sv ----
// memory end of the two-wire link, clocked by the link clock
//
// What this block and the master end do
// - protect pin high drops all write data
// - reads work at any protect level
// - master holds protect level start to stop
// - unconnected protect pin reads as low
// - byte write: start, word, low, data, stop
// - word gives upper bits, then low byte
// - page write steps address, wraps to zero
// - long page write keeps overwriting in order
// - buffer keeps last accessed 11-bit address
// - current read returns upper plus buffer plus one
// - current read after last location gives zero
// - buffer holds address zero after reset
// - random read: set address, restart, read
// - master repeats same upper bits on restart
// - master ends reading with not-acknowledge
// - sequential read steps address, wraps to zero
// - master only releases data line in recovery
// - master recovers by reset sequence or retry
// - device acknowledges its own word and each later byte low
// - device releases line after not-acknowledge
// - sample on rising, change after falling edge
`timescale 1ns/1ns
module ismc_mem_dev
#(
   // arbitrary value, not tied to any real part
   parameter logic [3:0] type_code = ismc_pkg::ISMC_TYPE_DEFAULT
)
(
   ismc_link_if.dev link,
   input wire logic rst,
   output logic wp_level,
   output logic busy
);
   import ismc_pkg::*;

   typedef enum logic [2:0] {
      D_IDLE,
      D_DEV,
      D_LOW,
      D_WR,
      D_RD
   } ismc_dst_e;

   ismc_dst_e st_q;
   logic [7:0] mem_q [0:ISMC_MEM_DEPTH-1];
   logic [3:0] cnt_q;
   logic [6:0] sh_q;
   logic ack_q;
   logic [ISMC_UPPER_W-1:0] upper_q;
   logic [ISMC_ADDR_W-1:0] addr_q;
   logic [ISMC_ADDR_W-1:0] nxt_q;
   logic fresh_q;
   logic [7:0] out_q;
   logic drv_q;
   logic start_tgl_q;
   logic start_seen_q;
   logic wp_s;
   logic start_pend;
   logic [7:0] byte_in;
   logic rx_done;
   logic ack_clk;
   logic dev_hit;
   logic word_rd;
   logic master_ack;
   logic [ISMC_ADDR_W-1:0] rd_ptr;

   // ==================================================
   // helpers

   // 11-bit step; the natural carry-out gives the wrap to zero
   function automatic logic [ISMC_ADDR_W-1:0] addr_inc(
      input logic [ISMC_ADDR_W-1:0] a);
      addr_inc = a + ISMC_ADDR_W'(1);
   endfunction : addr_inc

   // ==================================================
   // protect pin enters the link domain through two flops
   ismc_sync2 u_wp_sync (
      .clk (link.scl),
      .rst (rst),
      .d (link.wp),
      .q (wp_s)
   );

   assign wp_level = wp_s;
   assign busy = (st_q != D_IDLE);

   // ==================================================
   // start detection: data falls while the clock is high.
   // the toggle settles at least three quarters of a link period before the next rising
   // edge reads it, so a single flop is safe here
   always_ff @(negedge link.sda or posedge rst)
   begin
      if (rst)
         start_tgl_q <= 1'b0;
      else if (link.scl)
         start_tgl_q <= !start_tgl_q;
   end

   // ==================================================
   // decode of the current bit
   assign start_pend = (start_tgl_q != start_seen_q);
   assign byte_in = {sh_q, link.sda};
   assign rx_done = !start_pend && (cnt_q == ISMC_LAST_BIT)
      && (st_q == D_DEV || st_q == D_LOW || st_q == D_WR);
   assign ack_clk = !start_pend && (cnt_q == ISMC_ACK_BIT);
   assign dev_hit = (byte_in[ISMC_TYPE_MSB:ISMC_TYPE_LSB] == type_code);
   assign word_rd = byte_in[ISMC_RW_BIT];
   // master acknowledge after a byte that we sent
   assign master_ack = ack_clk && (st_q == D_RD) && !ack_q && !link.sda;

   // random read uses the address just set, current read uses n+1
   assign rd_ptr = fresh_q ? nxt_q
      : addr_inc({byte_in[ISMC_UPPER_MSB:ISMC_UPPER_LSB],
                  addr_q[7:0]});

   // ==================================================
   // bit counter and receive shifter, sampled on the rising edge
   always_ff @(posedge link.scl or posedge rst)
   begin
      if (rst)
      begin
         start_seen_q <= 1'b0;
         cnt_q <= ISMC_BIT_ZERO;
         sh_q <= 7'h00;
      end
      else
      begin
         sh_q <= {sh_q[5:0], link.sda};
         if (start_pend)
         begin
            start_seen_q <= start_tgl_q;
            cnt_q <= ISMC_BIT_ONE;
         end
         else if (ack_clk)
            cnt_q <= ISMC_BIT_ZERO;
         else
            cnt_q <= cnt_q + ISMC_BIT_ONE;
      end
   end

   // ==================================================
   // command state and acknowledge decision
   always_ff @(posedge link.scl or posedge rst)
   begin
      if (rst)
      begin
         st_q <= D_IDLE;
         ack_q <= 1'b0;
      end
      else if (start_pend)
      begin
         st_q <= D_DEV;
         ack_q <= 1'b0;
      end
      else if (rx_done)
      begin
         case (st_q)
            D_DEV:
            begin
               // a foreign type code sends us to standby, no acknowledge
               ack_q <= dev_hit;
               if (!dev_hit)
                  st_q <= D_IDLE;
               else if (word_rd)
                  st_q <= D_RD;
               else
                  st_q <= D_LOW;
            end
            D_LOW:
            begin
               ack_q <= 1'b1;
               st_q <= D_WR;
            end
            D_WR:
            begin
               ack_q <= 1'b1;
               st_q <= D_WR;
            end
            default:
            begin
               ack_q <= 1'b0;
               st_q <= D_IDLE;
            end
         endcase
      end
      else if (ack_clk)
      begin
         ack_q <= 1'b0;
         // not-acknowledge from the master ends the read
         if (st_q == D_RD && !ack_q && link.sda)
            st_q <= D_IDLE;
      end
   end

   // ==================================================
   // address buffer (last access) and next-address pointer.
   // the buffer is state, so reset loads it with address zero
   always_ff @(posedge link.scl or posedge rst)
   begin
      if (rst)
      begin
         upper_q <= 3'h0;
         addr_q <= ISMC_ADDR_ZERO;
         nxt_q <= ISMC_ADDR_ZERO;
         fresh_q <= 1'b0;
      end
      else if (rx_done && st_q == D_DEV && dev_hit)
      begin
         upper_q <= byte_in[ISMC_UPPER_MSB:ISMC_UPPER_LSB];
         if (word_rd)
         begin
            addr_q <= rd_ptr;
            nxt_q <= addr_inc(rd_ptr);
            fresh_q <= 1'b0;
         end
      end
      else if (rx_done && st_q == D_LOW)
      begin
         addr_q <= {upper_q, byte_in};
         nxt_q <= {upper_q, byte_in};
         fresh_q <= 1'b1;
      end
      else if (rx_done && st_q == D_WR)
      begin
         addr_q <= nxt_q;
         nxt_q <= addr_inc(nxt_q);
         fresh_q <= 1'b0;
      end
      else if (master_ack)
      begin
         addr_q <= nxt_q;
         nxt_q <= addr_inc(nxt_q);
      end
   end

   // ==================================================
   // array write; protected data is acknowledged but dropped
   always_ff @(posedge link.scl)
   begin
      if (rx_done && st_q == D_WR && !wp_s)
         mem_q[nxt_q] <= byte_in;
   end

   // ==================================================
   // read byte fetch, ahead of the first falling edge that sends it
   always_ff @(posedge link.scl or posedge rst)
   begin
      if (rst)
         out_q <= 8'h00;
      else if (rx_done && st_q == D_DEV && dev_hit && word_rd)
         out_q <= mem_q[rd_ptr];
      else if (master_ack)
         out_q <= mem_q[nxt_q];
   end

   // ==================================================
   // line driver changes only after falling edges; it never drives
   // high, it only pulls low or lets go
   always_ff @(negedge link.scl or posedge rst)
   begin
      if (rst)
         drv_q <= 1'b0;
      else if (start_pend)
         drv_q <= 1'b0;
      else if (cnt_q == ISMC_ACK_BIT)
         drv_q <= ack_q;
      else if (st_q == D_RD && cnt_q <= ISMC_LAST_BIT)
         drv_q <= !out_q[3'(ISMC_LAST_BIT - cnt_q)];
      else
         drv_q <= 1'b0;
   end

   assign link.sda_d_oe = drv_q;

endmodule : ismc_mem_dev

// ---- verilog/ismc_master.sv ----
// master end of the two-wire link: makes the link clock and sends bytes
`timescale 1ns/1ns
module ismc_master
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire ismc_pkg::ismc_op_e cmd_op,
   input wire logic [7:0] cmd_data,
   input wire logic cmd_nack,
   input wire logic wp_req,
   input wire logic wp_connect,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic rsp_ack,
   ismc_link_if.master link
);
   import ismc_pkg::*;

   typedef enum logic {
      H_IDLE,
      H_RUN
   } ismc_hst_e;

   ismc_hst_e st_q;
   ismc_op_e op_q;
   logic [7:0] qcnt_q;
   logic [1:0] ph_q;
   logic [3:0] bit_q;
   logic [8:0] tx_q;
   logic [7:0] rx_q;
   logic scl_q;
   logic oe_q;
   logic in_frame_q;
   logic wp_q;
   logic sda_s;
   logic tick;
   logic is_byte;
   logic done;
   logic scl_d;
   logic oe_d;

   // ==================================================
   // data line comes back through two flops
   ismc_sync2 u_sda_sync (
      .clk (ref_clk),
      .rst (rst),
      .d (link.sda),
      .q (sda_s)
   );

   assign cmd_ready = (st_q == H_IDLE);
   assign tick = (qcnt_q == ISMC_QTR_LAST);
   assign is_byte = (op_q == ISMC_OP_WRITE) || (op_q == ISMC_OP_READ)
      || (op_q == ISMC_OP_CLOCKS);
   assign done = tick && (ph_q == ISMC_PH_LAST)
      && (!is_byte || bit_q == ISMC_ACK_BIT);

   // ==================================================
   // waveform per quarter; a one in tx_q releases the line, since a
   // hard high could fight a device still pulling low
   always_comb
   begin
      scl_d = scl_q;
      oe_d = oe_q;
      case (op_q)
         ISMC_OP_START:
         begin
            scl_d = (ph_q == 2'h1) || (ph_q == 2'h2);
            oe_d = ph_q[1];
         end
         ISMC_OP_STOP:
         begin
            scl_d = (ph_q != 2'h0);
            oe_d = !ph_q[1];
         end
         default:
         begin
            scl_d = (ph_q == 2'h1) || (ph_q == 2'h2);
            oe_d = !tx_q[8];
         end
      endcase
   end

   // ==================================================
   // quarter timer and sequencing
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         st_q <= H_IDLE;
         op_q <= ISMC_OP_STOP;
         qcnt_q <= 8'h00;
         ph_q <= 2'h0;
         bit_q <= ISMC_BIT_ZERO;
         tx_q <= 9'h1FF;
      end
      else if (st_q == H_IDLE)
      begin
         qcnt_q <= 8'h00;
         ph_q <= 2'h0;
         bit_q <= ISMC_BIT_ZERO;
         if (cmd_valid)
         begin
            st_q <= H_RUN;
            op_q <= cmd_op;
            case (cmd_op)
               ISMC_OP_WRITE: tx_q <= {cmd_data, 1'b1};
               ISMC_OP_READ: tx_q <= {8'hFF, cmd_nack};
               default: tx_q <= 9'h1FF;
            endcase
         end
      end
      else
      begin
         qcnt_q <= tick ? 8'h00 : qcnt_q + 8'h01;
         if (done)
            st_q <= H_IDLE;
         else if (tick)
         begin
            ph_q <= ph_q + 2'h1;
            if (ph_q == ISMC_PH_LAST)
            begin
               bit_q <= bit_q + ISMC_BIT_ONE;
               tx_q <= {tx_q[7:0], 1'b1};
            end
         end
      end
   end

   // ==================================================
   // pins are registered; they hold their level while idle
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         scl_q <= 1'b1;
         oe_q <= 1'b0;
      end
      else if (st_q == H_RUN)
      begin
         scl_q <= scl_d;
         oe_q <= oe_d;
      end
   end

   // ==================================================
   // sample at the end of the high half of each bit
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         rx_q <= 8'h00;
         rsp_valid <= 1'b0;
         rsp_data <= 8'h00;
         rsp_ack <= 1'b0;
      end
      else
      begin
         rsp_valid <= 1'b0;
         if (st_q == H_RUN && is_byte && tick && ph_q == 2'h2)
         begin
            if (bit_q != ISMC_ACK_BIT)
               rx_q <= {rx_q[6:0], sda_s};
            else
            begin
               rsp_ack <= !sda_s;
               rsp_data <= rx_q;
               rsp_valid <= (op_q != ISMC_OP_CLOCKS);
            end
         end
      end
   end

   // ==================================================
   // protect level only changes outside a start..stop frame
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         in_frame_q <= 1'b0;
         wp_q <= 1'b0;
      end
      else
      begin
         if (st_q == H_IDLE && cmd_valid && cmd_op == ISMC_OP_START)
            in_frame_q <= 1'b1;
         else if (done && op_q == ISMC_OP_STOP)
            in_frame_q <= 1'b0;
         if (!in_frame_q && !(st_q == H_IDLE && cmd_valid))
            wp_q <= wp_req;
      end
   end

   assign link.scl = scl_q;
   assign link.sda_m_oe = oe_q;
   assign link.wp_o = wp_q;
   assign link.wp_oe = wp_connect;

endmodule : ismc_master

// ---- sim/ismc_link_checker.sv ----
// concurrent checks on the two-wire link between both ends
`timescale 1ns/1ns
module ismc_link_checker
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic scl,
   input wire logic sda_m_oe,
   input wire logic sda_d_oe,
   input wire logic sda,
   input wire logic wp_o,
   input wire logic wp_oe,
   input wire logic wp
);
   import ismc_pkg::*;
   // ==========================================
   // helper counters
   localparam int HOLD_MAX = 9 * 4 * ISMC_QTR_CYC;
   localparam int IDLE_MIN = 8 * ISMC_QTR_CYC;
   logic [11:0] hold_q;
   logic [9:0] idle_q;

   // run of cycles the memory end keeps the data line low
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         hold_q <= 12'h000;
      else if (sda_d_oe)
         hold_q <= hold_q + 12'h001;
      else
         hold_q <= 12'h000;
   end

   // saturating run of link clock high: long high means no frame
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         idle_q <= 10'h000;
      else if (!scl)
         idle_q <= 10'h000;
      else if (idle_q != 10'(IDLE_MIN))
         idle_q <= idle_q + 10'h001;
   end

   // ==========================================
   // properties
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   oe_low_change_a: assert property ($changed(sda_d_oe) |-> !scl)
      else $error("device data changed while clock high");
   oe_high_hold_a: assert property (
      $rose(scl) |-> ##1 $stable(sda_d_oe) [*8])
      else $error("device data moved after clock rise");
   wp_pull_a: assert property (!wp_oe |-> !wp)
      else $error("open protect pin not low");
   wp_follow_a: assert property (wp_oe |-> wp == wp_o)
      else $error("protect pin does not follow master");
   wp_frame_a: assert property ($changed(wp) |-> scl && sda)
      else $error("protect level moved inside a frame");
   release_bound_a: assert property (hold_q <= 12'(HOLD_MAX))
      else $error("device held data line too long");
   idle_free_a: assert property (
      idle_q == 10'(IDLE_MIN) |-> !sda_d_oe)
      else $error("device drives data line while idle");
   high_quiet_a: assert property (
      scl && $past(scl) && $changed(sda) |-> !sda_d_oe && !$past(sda_d_oe))
      else $error("device moved data line during clock high");

   ack_seen_c: cover property ($rose(sda_d_oe));
   start_c: cover property (scl && $fell(sda));
   stop_c: cover property (scl && $rose(sda));
   wp_on_c: cover property ($rose(wp));
   master_pull_c: cover property ($rose(sda_m_oe) && !scl);
endmodule : ismc_link_checker

// ---- sim/i2c_serial_memory_commands_tb.sv ----
// testbench: master and memory ends joined, command frames checked
`timescale 1ns/1ns
module i2c_serial_memory_commands_tb;
   import ismc_pkg::*;
   localparam int WAIT_MAX = 3000;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic cmd_valid = 1'b0;
   logic cmd_ready;
   ismc_op_e cmd_op = ISMC_OP_START;
   logic [7:0] cmd_data = 8'h00;
   logic cmd_nack = 1'b0;
   logic wp_req = 1'b0;
   logic wp_connect = 1'b1;
   logic rsp_valid;
   logic [7:0] rsp_data;
   logic rsp_ack;
   logic dev_wp_level;
   logic dev_busy;
   int failures = 0;
   int samples_checked = 0;

   ismc_link_if link ();

   ismc_master u_ismc_master (.ref_clk(ref_clk), .rst(rst),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
      .cmd_data(cmd_data), .cmd_nack(cmd_nack), .wp_req(wp_req),
      .wp_connect(wp_connect), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .rsp_ack(rsp_ack), .link(link));

   ismc_mem_dev u_ismc_mem_dev (.link(link), .rst(rst),
      .wp_level(dev_wp_level), .busy(dev_busy));

   ismc_link_checker u_ismc_link_checker (.ref_clk(ref_clk), .rst(rst),
      .scl(link.scl), .sda_m_oe(link.sda_m_oe), .sda_d_oe(link.sda_d_oe),
      .sda(link.sda), .wp_o(link.wp_o), .wp_oe(link.wp_oe), .wp(link.wp));

   always #2 ref_clk = ~ref_clk;

   // ==========================================
   // shared tasks
   task automatic check(logic [7:0] seen, logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic wrap_up();
      if (failures == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up

   // hold the request until the edge on which the master takes it
   task automatic issue(ismc_op_e op, logic [7:0] d, logic nk);
      int n;
      n = 0;
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_data <= d;
      cmd_nack <= nk;
      @(negedge ref_clk);
      while (cmd_ready !== 1'b1 && n < WAIT_MAX)
      begin
         @(negedge ref_clk);
         n++;
      end
      // a master that never comes back to idle counts as a mismatch
      if (n == WAIT_MAX)
         failures++;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
   endtask : issue

   // responses are one-cycle pulses, so look at every falling edge
   task automatic await(logic rsp);
      int n;
      n = 0;
      @(negedge ref_clk);
      while ((rsp ? rsp_valid : cmd_ready) !== 1'b1 && n < WAIT_MAX)
      begin
         @(negedge ref_clk);
         n++;
      end
      if (n == WAIT_MAX)
         failures++;
   endtask : await

   // start, stop and clocks end once the master is idle again
   task automatic op(ismc_op_e o);
      issue(o, 8'h00, 1'b0);
      await(1'b0);
      @(posedge ref_clk);
   endtask : op

   task automatic wrb(logic [7:0] d, logic exp_ack);
      issue(ISMC_OP_WRITE, d, 1'b0);
      await(1'b1);
      check({7'h00, rsp_ack}, {7'h00, exp_ack});
   endtask : wrb

   task automatic rdb(logic nk, logic [7:0] exp);
      issue(ISMC_OP_READ, 8'h00, nk);
      await(1'b1);
      check(rsp_data, exp);
   endtask : rdb

   function automatic logic [7:0] word(logic [2:0] up, logic rw);
      return {ISMC_TYPE_DEFAULT, up, rw};
   endfunction : word

   task automatic set_addr(logic [2:0] up, logic [7:0] lo);
      op(ISMC_OP_START);
      wrb(word(up, 1'b0), 1'b1);
      wrb(lo, 1'b1);
   endtask : set_addr

   // random read of one byte, closed by not-acknowledge
   task automatic rd_at(logic [2:0] up, logic [7:0] lo, logic [7:0] exp);
      set_addr(up, lo);
      op(ISMC_OP_START);
      wrb(word(up, 1'b1), 1'b1);
      rdb(1'b1, exp);
      op(ISMC_OP_STOP);
   endtask : rd_at

   // ==========================================
   // scenarios
   initial
   begin
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      // page write over the top location wraps to zero
      set_addr(3'h7, 8'hFE);
      check({7'h00, dev_busy}, 8'h01);
      wrb(8'hA5, 1'b1);
      wrb(8'h3C, 1'b1);
      wrb(8'h96, 1'b1);
      op(ISMC_OP_STOP);
      // sequential read of two bytes, buffer left on the last one
      set_addr(3'h7, 8'hFE);
      op(ISMC_OP_START);
      wrb(word(3'h7, 1'b1), 1'b1);
      rdb(1'b0, 8'hA5);
      rdb(1'b1, 8'h3C);
      op(ISMC_OP_STOP);
      // current read past the last location gives location zero
      op(ISMC_OP_START);
      wrb(word(3'h7, 1'b1), 1'b1);
      rdb(1'b1, 8'h96);
      op(ISMC_OP_STOP);
      check({7'h00, dev_busy}, 8'h00);
      // protected write is acknowledged but dropped; reads still work
      wp_req <= 1'b1;
      set_addr(3'h0, 8'h00);
      wrb(8'h11, 1'b1);
      check({7'h00, dev_wp_level}, 8'h01);
      op(ISMC_OP_STOP);
      rd_at(3'h0, 8'h00, 8'h96);
      // foreign type code is not acknowledged, then recovery
      op(ISMC_OP_START);
      wrb({4'h3, 3'h0, 1'b0}, 1'b0);
      check({7'h00, dev_busy}, 8'h00);
      op(ISMC_OP_START);
      op(ISMC_OP_CLOCKS);
      op(ISMC_OP_START);
      op(ISMC_OP_STOP);
      // open protect pin reads as low, so the write lands
      wp_connect <= 1'b0;
      set_addr(3'h0, 8'h00);
      wrb(8'h5A, 1'b1);
      check({7'h00, dev_wp_level}, 8'h00);
      op(ISMC_OP_STOP);
      rd_at(3'h0, 8'h00, 8'h5A);
      wp_connect <= 1'b1;
      wp_req <= 1'b0;
      wrap_up();
   end

   // cut a hang short well beyond the expected run length
   initial
   begin
      #400000;
      failures++;
      wrap_up();
   end
endmodule : i2c_serial_memory_commands_tb
